// *** sync_serial_spi_port.sv ***
/*
  Synchronous serial port in spi mode: apb register file, master
  clock generator, slave clock follower, msb-first shift logic,
  double-buffered receive and pin drive with direction overrides.
  Assumes pins arrive asynchronously and timer_tick is a one-cycle
  pulse on pclk.
*/
`timescale 1ns/1ps

module sync_serial_spi_port (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic [31:0]                    prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      timer_tick,
  input  wire sync_serial_pkg::pins_in_t pins_in,
  output sync_serial_pkg::pins_out_t     pins_out
);
  import sync_serial_pkg::*;

  // registered state and its next value
  state_t     state_reg;
  state_t     state_next;

  // decoded mode, options and clock edge roles
  logic       mode_master;
  logic       mode_slave;
  logic       enabled;
  logic       master;
  logic       slave;
  logic       selected;
  logic       clock_idle_polarity;
  logic       cke;
  logic       late_smp;
  logic       busy;
  logic       half;
  logic       step;
  logic       lead;
  logic       sample;
  logic       shift;
  logic       done;

  // counters, bytes, bus and pin helpers
  logic [4:0] edge_nx;
  logic [5:0] half_len;
  logic [7:0] rx_byte;
  logic [7:0] rdata;
  logic       hit;
  logic       access;
  logic       sdi_bit;
  logic       commit;
  logic       sck_drive;
  logic       sdo_drive;

  // decode of mode and option bits
  always_comb begin
    enabled  = state_reg.serial_port_control[CTRL_EN];
    clock_idle_polarity      = state_reg.serial_port_control[CTRL_CKP];
    cke      = state_reg.clock_edge_bit;
    // clock rate only counts in master, select only in slave [RULE5]
    case (state_reg.serial_port_control[3:0])
      MODE_DIV4, MODE_DIV16, MODE_DIV64, MODE_TIMER: begin
        mode_master = 1'b1;
        mode_slave  = 1'b0;
      end
      MODE_SLV_SS, MODE_SLV: begin
        mode_master = 1'b0;
        mode_slave  = 1'b1;
      end
      default: begin
        // the remaining codes leave the port doing nothing
        mode_master = 1'b0;
        mode_slave  = 1'b0;
      end
    endcase
    master   = enabled && mode_master;
    slave    = enabled && mode_slave;
    // select gates mode 4; an output-programmed select pin deselects
    selected = slave &&
               (state_reg.serial_port_control[3:0] == MODE_SLV ||
                (!state_reg.ss_sync[1] &&
                 state_reg.pin_direction[DIR_SS])); // [RULE20] [RULE19]
    // end-of-time sampling applies in master only [RULE4]
    late_smp = master && state_reg.sample_phase_bit;
    busy     = state_reg.phase == RUN || state_reg.edge_cnt != 5'h00;
    sdi_bit  = state_reg.sdi_sync[1];
  end

  // divider: clk/4, /16, /64 or timer pulse per half bit [RULE22]
  always_comb begin
    case (state_reg.serial_port_control[3:0])
      MODE_DIV4:  half_len = HALF_DIV4;
      MODE_DIV16: half_len = HALF_DIV16;
      MODE_DIV64: half_len = HALF_DIV64;
      default:    half_len = HALF_DIV4;
    endcase
    // timer mode counts timer pulses, not the divider
    if (state_reg.serial_port_control[3:0] == MODE_TIMER) begin
      half = timer_tick;
    end else begin
      half = state_reg.div_cnt == half_len - 6'h01;
    end
  end

  // clock edge detection, edge role and byte completion
  always_comb begin
    step = 1'b0;
    lead = 1'b0;
    if (master && state_reg.phase == RUN) begin
      // master toggles its own clock [RULE2]
      step = half;
      lead = state_reg.sck_level == clock_idle_polarity;
    end else if (selected) begin
      // slave follows the synchronised far-side clock [RULE2]
      step = state_reg.sck_sync[1] != state_reg.sck_sync[2];
      lead = state_reg.sck_sync[2] == clock_idle_polarity;
    end
    edge_nx = state_reg.edge_cnt + 5'h01;
    // sampling sits opposite the shifting edge, or one half later
    sample  = step &&
              (((lead == (cke ^ late_smp)) &&
                !(late_smp && !cke && edge_nx == 5'h01)) ||
               (late_smp && !cke && edge_nx == EDGES_BYTE)); // [RULE4]
    // set edge bit shifts on active-to-idle, clear on idle-to-active
    shift   = step && (lead != cke) && edge_nx != 5'h01; // [RULE21]
    done    = step && edge_nx == EDGES_BYTE;
    // received byte as it stands after this sample
    rx_byte = {state_reg.rx_shift[6:0], sdi_bit};
  end

  // apb read mux; the shift register has no address [RULE14]
  always_comb begin
    rdata = 8'h00;
    hit   = 1'b1;
    case (paddr)
      CTRL_OFS: rdata = state_reg.serial_port_control;
      STAT_OFS: begin
        rdata[STAT_SMP] = state_reg.sample_phase_bit;
        rdata[STAT_CKE] = state_reg.clock_edge_bit;
        rdata[STAT_BF]  = state_reg.buffer_full_flag;
      end
      BUF_OFS:  rdata = state_reg.transfer_buffer;
      DIR_OFS:  rdata = state_reg.pin_direction;
      EVT_OFS:  rdata[EVT_FLAG] = state_reg.port_interrupt_flag;
      default:  hit = 1'b0;
    endcase
  end

  // next state: bus, shifting, flags and pin drive
  always_comb begin
    state_next = state_reg;
    access     = psel && penable;
    commit     = access && state_reg.pready;

    // input synchronisers; data and select read at the second stage, clock at the second and third
    state_next.sck_sync = {state_reg.sck_sync[1:0], pins_in.sck};
    state_next.sdi_sync = {state_reg.sdi_sync[0], pins_in.serial_in_pin};
    state_next.ss_sync  = {state_reg.ss_sync[0], pins_in.ss_n};

    // master divider runs only while a byte is moving
    if (master && state_reg.phase == RUN && !half) begin
      state_next.div_cnt = state_reg.div_cnt + 6'h01;
    end else begin
      state_next.div_cnt = 6'h00;
    end

    // clock edges move the counters and the two shift registers
    if (step) begin
      state_next.edge_cnt = edge_nx;
      if (master) begin
        state_next.sck_level = ~state_reg.sck_level;
      end
    end
    if (shift) begin
      // msb leaves first [RULE6]
      state_next.shift_register = {state_reg.shift_register[6:0],
                                   1'b0};
    end
    if (sample) begin
      // msb arrives first, in step with transmit [RULE6]
      state_next.rx_shift = rx_byte;
      state_next.bit_cnt  = state_reg.bit_cnt + 4'h1;
    end
    if (done) begin
      state_next.edge_cnt = 5'h00;
      state_next.phase    = IDLE;
    end

    // idle master clock rests at the polarity level [RULE3]
    if (!(master && state_reg.phase == RUN)) begin
      state_next.sck_level = clock_idle_polarity;
    end

    // disable or a raised select returns the bit counter to zero
    if (!enabled || (slave && !selected)) begin
      state_next.phase    = IDLE;
      state_next.edge_cnt = 5'h00;
      state_next.bit_cnt  = 4'h0;
      state_next.div_cnt  = 6'h00;
    end

    // apb: access phase one wait cycle, then commit
    if (access && !state_reg.pready) begin
      state_next.pready  = 1'b1;
      state_next.pslverr = !hit;
      state_next.prdata  = pwrite ? 32'h0000_0000 : {24'h000000, rdata};
    end
    // commit edge: writes land and buffer reads clear buffer-full
    if (commit) begin
      state_next.pready  = 1'b0;
      state_next.pslverr = 1'b0;
      if (pwrite) begin
        case (paddr)
          CTRL_OFS: begin
            // software owns clearing of collision and overflow [RULE11]
            state_next.serial_port_control = pwdata[7:0];
          end
          STAT_OFS: begin
            state_next.sample_phase_bit = pwdata[STAT_SMP];
            state_next.clock_edge_bit   = pwdata[STAT_CKE];
          end
          BUF_OFS: begin
            if (busy) begin
              // write dropped while a byte moves [RULE10]
              state_next.serial_port_control[CTRL_WRITE_COLLISION_FLAG] = 1'b1;
            end else begin
              // load shift register at once [RULE24]
              state_next.transfer_buffer = pwdata[7:0];
              state_next.shift_register  = pwdata[7:0];
              state_next.bit_cnt         = 4'h0;
              if (master) begin
                state_next.phase    = RUN; // [RULE24]
                state_next.edge_cnt = 5'h00;
                state_next.div_cnt  = 6'h00;
              end
            end
          end
          DIR_OFS: state_next.pin_direction = pwdata[7:0];
          EVT_OFS: begin
            if (pwdata[EVT_FLAG]) begin
              state_next.port_interrupt_flag = 1'b0;
            end
          end
          default: begin
          end
        endcase
      end else if (paddr == BUF_OFS) begin
        state_next.buffer_full_flag = 1'b0; // [RULE12]
      end
    end

    // completed byte: after the bus so a same-cycle set wins
    if (sample && state_reg.bit_cnt == LAST_BIT) begin
      state_next.bit_cnt = 4'h0;
      if (slave && state_reg.buffer_full_flag) begin
        // unread byte kept, overflow flagged [RULE23]
        state_next.serial_port_control[CTRL_OVF] = 1'b1;
      end else begin
        // received byte to buffer while next may follow [RULE7] [RULE9]
        state_next.transfer_buffer  = rx_byte;
        state_next.buffer_full_flag = 1'b1; // [RULE8]
      end
      state_next.port_interrupt_flag = 1'b1; // [RULE8]
    end

    // pin drive; enable hands pins over [RULE15]
    state_next.pins.sck      = state_next.sck_level;
    // clock output only in master with direction bit clear [RULE2]
    sck_drive = master && !state_reg.pin_direction[DIR_SCK];
    state_next.pins.sck_oe_n = !sck_drive;
    state_next.pins.serial_out_pin      = state_next.shift_register[7];
    // data-out released when deselected or overridden [RULE19]
    sdo_drive = (master || selected) && !state_reg.pin_direction[DIR_SDO];
    state_next.pins.sdo_oe_n = !sdo_drive;
    // data-in has no direction control at all [RULE17]
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg                     <= '0;
      state_reg.serial_port_control <= CTRL_RST;
      state_reg.pin_direction       <= DIR_RST;
      state_reg.pins.sck_oe_n       <= 1'b1;
      state_reg.pins.sdo_oe_n       <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs straight from the state register
  assign prdata   = state_reg.prdata;
  assign pready   = state_reg.pready;
  assign pslverr  = state_reg.pslverr;
  assign pins_out = state_reg.pins;

endmodule

// *** sync_serial_pkg.sv ***
/*
  Constants, field positions and carrier types of the synchronous
  serial port (spi mode) reached over apb.
  Assumes a 32-bit apb bus on pclk with byte addresses on paddr.
*/
// Summary of operation
// RULE1: software sets options before starting transfers
// RULE2: master drives serial clock, slave receives it
// RULE3: polarity bit sets idle clock level
// RULE4: sample bit picks middle or end sampling
// RULE5: rate only in master, select only slave
// RULE6: shift register moves data msb first, duplex
// RULE7: eight bits in, byte copied to buffer
// RULE8: each copy sets buffer-full and interrupt flag
// RULE9: next byte shifts while old byte waits
// RULE10: busy buffer write dropped, collision flag set
// RULE11: software alone clears the collision flag
// RULE12: reading the buffer clears buffer-full
// RULE13: software reads buffer before next write
// RULE14: shift register reachable only through buffer
// RULE15: enable bit hands pins to serial port
// RULE16: reconfigure by clearing, rewriting, then enabling
// RULE17: data-in pin direction handled by port
// RULE18: software programs data-out, clock, select directions
// RULE19: opposite direction bit overrides serial function
// RULE20: mode 4 shifts only while select low
// RULE21: edge bit picks which transition shifts out
// RULE22: master rate clk/4, /16, /64, timer/2
// RULE23: slave full-buffer completion sets overflow, keeps
// RULE24: idle buffer write loads, master starts

package sync_serial_pkg;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] BUF_OFS  = 8'h08;
  localparam logic [7:0] DIR_OFS  = 8'h0c;
  localparam logic [7:0] EVT_OFS  = 8'h10;

  // field positions
  localparam int CTRL_WRITE_COLLISION_FLAG = 7;
  localparam int CTRL_OVF  = 6;
  localparam int CTRL_EN   = 5;
  localparam int CTRL_CKP  = 4;
  localparam int STAT_SMP  = 7;
  localparam int STAT_CKE  = 6;
  localparam int STAT_BF   = 0;
  localparam int DIR_SDO   = 7;
  localparam int DIR_SCK   = 1;
  localparam int DIR_SS    = 5;
  localparam int EVT_FLAG  = 0;

  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DIR_RST  = 8'hff;

  // mode field codes
  localparam logic [3:0] MODE_DIV4   = 4'h0;
  localparam logic [3:0] MODE_DIV16  = 4'h1;
  localparam logic [3:0] MODE_DIV64  = 4'h2;
  localparam logic [3:0] MODE_TIMER  = 4'h3;
  localparam logic [3:0] MODE_SLV_SS = 4'h4;
  localparam logic [3:0] MODE_SLV    = 4'h5;

  // timing counts: pclk cycles per half bit, edges per byte, last bit number
  localparam logic [5:0] HALF_DIV4  = 6'h02;
  localparam logic [5:0] HALF_DIV16 = 6'h08;
  localparam logic [5:0] HALF_DIV64 = 6'h20;
  localparam logic [4:0] EDGES_BYTE = 5'h10;
  localparam logic [3:0] LAST_BIT   = 4'h7;

  typedef enum logic {IDLE, RUN} phase_t;

  typedef struct packed {
    logic sck;
    logic serial_in_pin;
    logic ss_n;
  } pins_in_t;

  typedef struct packed {
    logic sck;
    logic sck_oe_n;
    logic serial_out_pin;
    logic sdo_oe_n;
  } pins_out_t;

  typedef struct packed {
    logic [7:0]  serial_port_control;
    logic        sample_phase_bit;
    logic        clock_edge_bit;
    logic        buffer_full_flag;
    logic        port_interrupt_flag;
    logic [7:0]  pin_direction;
    logic [7:0]  transfer_buffer;
    logic [7:0]  shift_register;
    logic [7:0]  rx_shift;
    phase_t      phase;
    logic [4:0]  edge_cnt;
    logic [3:0]  bit_cnt;
    logic [5:0]  div_cnt;
    logic        sck_level;
    logic [2:0]  sck_sync;
    logic [1:0]  sdi_sync;
    logic [1:0]  ss_sync;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    pins_out_t   pins;
  } state_t;

endpackage

// *** sync_serial_spi_port_properties.sv ***
/*
  Checker of the spi port: apb answer, pin drive and master timing.
  Assumes it is bound to the port top and sees only its ports.
*/
`timescale 1ns/1ps
module sync_serial_spi_port_properties (
  input wire logic                       pclk,
  input wire logic                       presetn,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [7:0]                 paddr,
  input wire logic [31:0]                pwdata,
  input wire logic [31:0]                prdata,
  input wire logic                       pready,
  input wire logic                       pslverr,
  input wire sync_serial_pkg::pins_in_t  pins_in,
  input wire sync_serial_pkg::pins_out_t pins_out
);
  import sync_serial_pkg::*;
  logic [7:0] cfg_reg, dir_reg;
  logic [4:0] tgl_reg;
  logic       run_reg, sck_reg, wr, mst, drv;
  // accepted writes, master mode and clock drive wanted
  assign wr = psel && penable && pready && pwrite;
  assign mst = cfg_reg[CTRL_EN] && cfg_reg[3:2] == 2'h0;
  assign drv = mst && !dir_reg[DIR_SCK];
  // shadow of control and direction; clock edges counted per byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= CTRL_RST;
      dir_reg <= DIR_RST;
      run_reg <= 1'b0;
      sck_reg <= 1'b0;
      tgl_reg <= 5'h00;
    end else begin
      sck_reg <= pins_out.sck;
      if (wr && paddr == CTRL_OFS)
        cfg_reg <= pwdata[7:0];
      if (wr && paddr == DIR_OFS)
        dir_reg <= pwdata[7:0];
      if (!mst || tgl_reg == EDGES_BYTE) begin
        run_reg <= 1'b0;
        tgl_reg <= 5'h00;
      end else begin
        if (wr && paddr == BUF_OFS)
          run_reg <= 1'b1;
        if (run_reg && pins_out.sck != sck_reg)
          tgl_reg <= tgl_reg + 5'h01;
      end
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_apb_answer: assert property (
    psel && !penable |-> ##[1:2] pready) else $error("apb answer late");
  chk_unmapped_err: assert property (
    pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > EVT_OFS))
    else $error("slave error on wrong address");
  chk_sck_drive: assert property (
    !pins_out.sck_oe_n |-> drv || $past(drv)) else $error("sck driven");
  chk_sdo_override: assert property (
    dir_reg[DIR_SDO] && $past(dir_reg[DIR_SDO]) |-> pins_out.sdo_oe_n)
    else $error("sdo driven though set as input");
  chk_slave_select: assert property (
    (cfg_reg[3:0] == MODE_SLV_SS && pins_in.ss_n) [*4] |->
    pins_out.sdo_oe_n) else $error("sdo driven while deselected");
  chk_sck_idle: assert property (
    mst && $past(mst, 2) && !run_reg && !pins_out.sck_oe_n |->
    pins_out.sck == cfg_reg[CTRL_CKP]) else $error("sck idle level");
  chk_byte_len: assert property (
    $rose(run_reg) && cfg_reg[1:0] == 2'h0 |-> ##[28:40] !run_reg)
    else $error("byte length wrong at fastest rate");
  chk_start_prompt: assert property (
    $rose(run_reg) && cfg_reg[1:0] == 2'h0 |-> ##[1:5]
    pins_out.sck != sck_reg) else $error("transfer start late");
endmodule
bind sync_serial_spi_port sync_serial_spi_port_properties u_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .pins_in, .pins_out);

// *** spi_far_model.sv ***
/*
  Far-side spi device: slave (idle low clock, shift on falling) when
  the port is master, master with select when the port is slave.
  Assumes the bench resolves the shared clock and data-out wires.
*/
`timescale 1ns/1ps
module spi_far_model (
  input  wire logic pclk,
  input  wire logic sck_w,
  input  wire logic sdo_w,
  output logic      serial_in_pin,
  output logic      sck_o,
  output logic      ss_n
);
  logic [7:0] tx_sh, rx_sh, s;
  logic       sck_q;
  initial {serial_in_pin, sck_o, ss_n, sck_q} = 4'h2;
  // slave role: capture on rising clock, next bit on falling
  always @(posedge pclk) begin
    sck_q <= sck_w;
    if (ss_n && sck_w && !sck_q)
      rx_sh <= {rx_sh[6:0], sdo_w};
    if (ss_n && !sck_w && sck_q) begin
      tx_sh <= {tx_sh[6:0], ~tx_sh[0]};
      serial_in_pin <= tx_sh[6];
    end
  end
  // preload the byte that the slave role returns, msb first
  task load(input logic [7:0] b);
    tx_sh <= b;
    serial_in_pin <= b[7];
  endtask
  // master role: clock stands low outside the frame
  task send(input logic [7:0] b, output logic [7:0] got);
    s = b;
    ss_n <= 1'b0;
    serial_in_pin <= s[7];
    repeat (8) begin
      repeat (6) @(posedge pclk);
      sck_o <= 1'b1;
      got = {got[6:0], sdo_w};
      repeat (6) @(posedge pclk);
      sck_o <= 1'b0;
      s = {s[6:0], ~s[0]};
      serial_in_pin <= s[7];
    end
    repeat (6) @(posedge pclk);
    ss_n <= 1'b1;
  endtask
endmodule

// *** sync_serial_spi_port_tb_top.sv ***
/*
  Bench of the spi port: apb tasks, far-side model, scenario tasks.
  Assumes the checker is bound in and the package compiled first.
*/
`timescale 1ns/1ps
`define CHK(g, e) check_eq(32'(g), 32'(e))
module sync_serial_spi_port_tb_top;
  import sync_serial_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic        sck_w, sdo_w, far_sdi, far_sck, far_ss_n, timer_tick;
  logic [7:0]  paddr, got;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  tdiv = 2'h0;
  pins_in_t    pins_in;
  pins_out_t   pins_out;
  int          error_cnt, comparisons;
  // shared wires resolved from enables; timer pulses every fourth clock
  assign sck_w = pins_out.sck_oe_n ? far_sck : pins_out.sck;
  assign sdo_w = pins_out.sdo_oe_n ? ~pins_out.serial_out_pin : pins_out.serial_out_pin;
  assign pins_in = '{sck: sck_w, serial_in_pin: far_sdi, ss_n: far_ss_n};
  assign timer_tick = tdiv == 2'h0;
  always @(posedge pclk) tdiv <= tdiv + 2'h1;
  sync_serial_spi_port dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .timer_tick, .pins_in,
    .pins_out);
  spi_far_model far (.pclk, .sck_w, .sdo_w, .serial_in_pin(far_sdi),
    .sck_o(far_sck), .ss_n(far_ss_n));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  function automatic void check_eq(logic [31:0] g, logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endfunction
  // one apb transfer; read data and error kept in rd and er
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // wait for the answer however long; only the watchdog ends it
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task rdc(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e);
  endtask
  // poll the full flag instead of the interrupt
  task wait_bf;
    rd = 32'h0;
    for (int k = 0; k < 300 && rd[STAT_BF] !== 1'b1; k++)
      apb(1'b0, STAT_OFS, 32'h0);
    `CHK(rd[STAT_BF], 1'b1);
  endtask
  task t_regs;
    rdc(CTRL_OFS, CTRL_RST);
    rdc(DIR_OFS, DIR_RST);
    wr(8'h14, 8'h5a);
    rdc(8'h14, 8'h00);
    `CHK(er, 1'b1);
  endtask
  task t_master;
    wr(DIR_OFS, 8'h7d);
    wr(STAT_OFS, 8'h40);
    wr(CTRL_OFS, 8'h21);
    far.load(8'h3c);
    wr(BUF_OFS, 8'ha5);
    wr(BUF_OFS, 8'h5a);
    rdc(CTRL_OFS, 8'ha1);
    wait_bf;
    rdc(BUF_OFS, 8'h3c);
    `CHK(far.rx_sh, 8'ha5);
    rdc(STAT_OFS, 8'h40);
    rdc(EVT_OFS, 8'h01);
    wr(EVT_OFS, 8'h01);
    rdc(EVT_OFS, 8'h00);
    rdc(CTRL_OFS, 8'ha1);
    wr(CTRL_OFS, 8'h21);
    rdc(CTRL_OFS, 8'h21);
  endtask
  // late sampling in master at clk/16 against a falling-edge far slave
  task t_late;
    wr(STAT_OFS, 8'hc0);
    far.load(8'h69);
    wr(BUF_OFS, 8'h96);
    wait_bf;
    rdc(BUF_OFS, 8'h69);
    `CHK(far.rx_sh, 8'h96);
    rdc(STAT_OFS, 8'hc0);
    wr(STAT_OFS, 8'h40);
  endtask
  task t_slave;
    wr(CTRL_OFS, 8'h00);
    wr(DIR_OFS, 8'h7f);
    wr(CTRL_OFS, 8'h24);
    wr(BUF_OFS, 8'hc3);
    far.send(8'h96, got);
    `CHK(got, 8'hc3);
    rdc(STAT_OFS, 8'h41);
    far.send(8'h11, got);
    rdc(CTRL_OFS, 8'h64);
    rdc(BUF_OFS, 8'h96);
  endtask
  // every master rate, clock idling high
  task t_rates;
    wr(DIR_OFS, 8'h7d);
    for (int m = 0; m < 4; m++) begin
      wr(CTRL_OFS, 8'h00);
      wr(CTRL_OFS, 8'h30 | 8'(m));
      repeat (3) @(posedge pclk);
      `CHK(pins_out.sck, 1'b1);
      wr(BUF_OFS, 8'(m));
      wait_bf;
      apb(1'b0, BUF_OFS, 32'h0);
    end
  endtask
  task final_report;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_master;
    t_late;
    t_slave;
    t_rates;
    final_report;
  end
  // watchdog: the run needs far fewer than 20000 clocks
  initial begin
    #400000;
    error_cnt++;
    final_report;
  end
endmodule
